// [pkg/pws_regs.svh]
// Purpose: register offsets, field positions, reset values of the waveform source
// Assumes: word-addressed plain register port, 8-bit address
// Notes:   sample memory is reached through a window of its own
`ifndef PWS_REGS_SVH
`define PWS_REGS_SVH

`define PWS_ADDR_CTRL      8'h00
`define PWS_ADDR_WIDTH     8'h01
`define PWS_ADDR_PINMAP    8'h02
`define PWS_ADDR_MEMADDR   8'h03
`define PWS_ADDR_MEMDATA   8'h04
`define PWS_ADDR_STATUS    8'h05
`define PWS_ADDR_COUNT     8'h06

`define PWS_CTRL_PARALLEL  0
`define PWS_CTRL_LSBFIRST  1
`define PWS_CTRL_PERSITE   2

`define PWS_RST_CTRL       3'h0
`define PWS_RST_WIDTH      6'h20
`define PWS_RST_PINMAP     32'h00000000

`endif

// [pkg/pws_pkg.sv]
// Purpose: types shared by the waveform source files
// Assumes: pws_regs.svh holds the numbers
// Notes:   none
package pws_pkg;
   // opcode of the current vector, as the sequencer hands it over
   typedef enum logic [1:0] {
      PWS_OP_NONE,
      PWS_OP_START,
      PWS_OP_SOURCE
   } pws_op_t;

   // one vector from the pattern sequencer
   typedef struct packed {
      logic    valid;
      pws_op_t op;
   } pws_vec_t;

   // per-sample configuration
   typedef struct packed {
      logic       parallel;
      logic       lsb_first;
      logic       per_site;
      logic [5:0] width;
   } pws_cfg_t;
endpackage

// [rtl/pws_bit_select.sv]
// Purpose: picks the serial bit of a sample given bit index and order
// Assumes: width is 1 to 32, index below width
// Notes:   purely combinational
`timescale 1ns/1ps
`default_nettype none
module pws_bit_select #(
   parameter int W = 32
) (
   // sample and position
   input  wire logic [W-1:0]         sample,
   input  wire logic [5:0]           index,
   input  wire logic [5:0]           width,
   input  wire logic                 lsb_first,
   // chosen bit
   output logic                      bit_out
);
   logic [5:0] pos; // bit position within the sample

   // msb first counts down from width-1, lsb first counts up from 0
   always_comb begin
      if (lsb_first) begin
         pos = index;
      end else begin
         pos = width - 6'h01 - index;
      end
      bit_out = sample[pos[4:0]];
   end
endmodule
`default_nettype wire

// [rtl/pws_source.sv]
// Purpose: drives stored waveform samples onto tested-device pins per vector
// Assumes: sequencer vectors are synchronous to core_clk
// Notes:   sample memory depth and site count are parameters
`timescale 1ns/1ps
`default_nettype none
`include "pws_regs.svh"

// What this block does
// - serial sourcing vector shifts exactly one bit
// - parallel vector drives whole sample across pins
// - serial sample width one to thirty-two bits
// - serial bit order selects msb or lsb first
// - broadcast drives site 0 data everywhere
// - per-site mapping uses each site's column
// - leftmost parallel bit drives first pin
// - group top pin takes leftmost bit
// - several waveforms per burst, one configuration
// - data only via start then source opcodes
module pws_source #(
   parameter int SITES = 4,
   parameter int PINS  = 32,
   parameter int DEPTH = 256,
   parameter int AW    = 8
) (
   // clock and reset
   input  wire logic                   core_clk,
   input  wire logic                   reset,
   // register port
   input  wire logic [7:0]             reg_addr,
   input  wire logic [31:0]            reg_wdata,
   input  wire logic                   reg_wr,
   input  wire logic                   reg_rd,
   output logic [31:0]                 reg_rdata,
   // pattern sequencer
   input  wire pws_pkg::pws_vec_t      vec,
   input  wire logic [SITES*PINS-1:0]  drive_from_src,
   // tested-device pin data per site and pin
   output logic [SITES*PINS-1:0]       pin_data,
   output logic [SITES*PINS-1:0]       pin_drive
);
   localparam int SW = 32; // stored sample width

   // sample memory, one column per site
   logic [SW-1:0] mem [SITES][DEPTH];

   // configuration registers
   pws_pkg::pws_cfg_t cfg, next_cfg;          // mode, order, mapping, width
   logic [31:0]       pinmap, next_pinmap;    // pin carrying the serial bit
   logic [AW+$clog2(SITES)-1:0] maddr, next_maddr; // memory write pointer

   // streaming state
   logic [AW-1:0]     ptr, next_ptr;          // current sample index
   logic [5:0]        bidx, next_bidx;        // current serial bit index
   logic              armed, next_armed;      // a start has been seen
   logic [31:0]       samples, next_samples;  // samples fully sent since the last start
   logic [SITES*PINS-1:0] next_pin_data;
   logic [SITES*PINS-1:0] next_pin_drive;
   logic [SITES-1:0]  ser_bit;                // serial bit per site
   logic [SW-1:0]     par_word [SITES];       // current sample per site after mapping
   logic              src_hit;                // sourcing vector after start
   logic              mem_we;                 // memory window write

   assign src_hit = vec.valid && vec.op == pws_pkg::PWS_OP_SOURCE && armed;
   assign mem_we  = reg_wr && reg_addr == `PWS_ADDR_MEMDATA;

   // configuration next values; memory pointer auto-increments on data writes
   always_comb begin
      next_cfg    = cfg;
      next_pinmap = pinmap;
      next_maddr  = maddr;
      if (reg_wr) begin
         case (reg_addr)
            `PWS_ADDR_CTRL: begin
               next_cfg.parallel  = reg_wdata[`PWS_CTRL_PARALLEL];
               next_cfg.lsb_first = reg_wdata[`PWS_CTRL_LSBFIRST];
               next_cfg.per_site  = reg_wdata[`PWS_CTRL_PERSITE];
            end
            `PWS_ADDR_WIDTH: begin
               // 0 or above 32 loads 32 so a bad write cannot stall the pointer
               if (reg_wdata[5:0] == 6'h00 || reg_wdata[5:0] > 6'h20) begin
                  next_cfg.width = 6'h20;
               end else begin
                  next_cfg.width = reg_wdata[5:0];
               end
            end
            `PWS_ADDR_PINMAP:  next_pinmap = reg_wdata;
            `PWS_ADDR_MEMADDR: next_maddr = reg_wdata[AW+$clog2(SITES)-1:0];
            `PWS_ADDR_MEMDATA: next_maddr = maddr + 1'b1;
            default: ;
         endcase
      end
   end

   // configuration registers
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         cfg       <= '{parallel: 1'b0, lsb_first: 1'b0, per_site: 1'b0,
                        width: `PWS_RST_WIDTH};
         pinmap    <= `PWS_RST_PINMAP;
         maddr     <= '0;
      end else begin
         cfg       <= next_cfg;
         pinmap    <= next_pinmap;
         maddr     <= next_maddr;
      end
   end

   // memory write: site in the upper bits, sample index below; no reset on storage
   always_ff @(posedge core_clk) begin
      if (mem_we) begin
         mem[maddr[AW+$clog2(SITES)-1:AW]][maddr[AW-1:0]] <= reg_wdata;
      end
   end

   // serial bit pick per site; broadcast reads site 0 column
   for (genvar s = 0; s < SITES; s++) begin : g_ser
      logic [SW-1:0] col_sample;
      assign col_sample = cfg.per_site ? mem[s][ptr] : mem[0][ptr];
      // named word so the parallel path can index it bit by bit
      assign par_word[s] = col_sample;
      pws_bit_select #(.W(SW)) u_sel (
         .sample    (col_sample),
         .index     (bidx),
         .width     (cfg.width),
         .lsb_first (cfg.lsb_first),
         .bit_out   (ser_bit[s])
      );
   end

   // pointer and bit counter; start rewinds, each full sample steps on
   always_comb begin
      next_ptr     = ptr;
      next_bidx    = bidx;
      next_armed   = armed;
      next_samples = samples;
      if (vec.valid && vec.op == pws_pkg::PWS_OP_START) begin
         // a new waveform in the same burst reuses the configuration
         next_ptr     = '0;
         next_bidx    = '0;
         next_armed   = 1'b1;
         next_samples = '0;
      end else if (src_hit) begin
         if (cfg.parallel) begin
            next_ptr     = ptr + 1'b1;
            next_samples = samples + 32'h00000001;
         end else if (bidx == cfg.width - 6'h01) begin
            next_bidx    = '0;
            next_ptr     = ptr + 1'b1;
            next_samples = samples + 32'h00000001;
         end else begin
            next_bidx    = bidx + 6'h01;
         end
      end
   end

   // pointer registers
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         ptr     <= '0;
         bidx    <= '0;
         armed   <= 1'b0;
         samples <= '0;
      end else begin
         ptr     <= next_ptr;
         bidx    <= next_bidx;
         armed   <= next_armed;
         samples <= next_samples;
      end
   end

   // pin data: serial puts one bit on the mapped pin, parallel spreads the sample
   always_comb begin
      next_pin_data  = pin_data;
      next_pin_drive = '0;
      for (int s = 0; s < SITES; s++) begin
         for (int p = 0; p < PINS; p++) begin
            if (src_hit && drive_from_src[s*PINS+p]) begin
               if (cfg.parallel) begin
                  // first listed pin (p=0, group top) takes leftmost bit
                  next_pin_data[s*PINS+p] = par_word[s][SW-1-p];
                  next_pin_drive[s*PINS+p] = 1'b1;
               end else if (p == int'(pinmap[4:0])) begin
                  // only the chosen pin sources; pattern keeps others off
                  next_pin_data[s*PINS+p]  = ser_bit[s];
                  next_pin_drive[s*PINS+p] = 1'b1;
               end
            end
         end
      end
   end

   // pin registers
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         pin_data  <= '0;
         pin_drive <= '0;
      end else begin
         pin_data  <= next_pin_data;
         pin_drive <= next_pin_drive;
      end
   end

   // read data, one cycle after the strobe; unmapped reads zero
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         reg_rdata <= '0;
      end else if (reg_rd) begin
         case (reg_addr)
            `PWS_ADDR_CTRL:    reg_rdata <= {29'h0, cfg.per_site, cfg.lsb_first,
                                             cfg.parallel};
            `PWS_ADDR_WIDTH:   reg_rdata <= {26'h0, cfg.width};
            `PWS_ADDR_PINMAP:  reg_rdata <= pinmap;
            `PWS_ADDR_MEMADDR: reg_rdata <= 32'(maddr);
            `PWS_ADDR_STATUS:  reg_rdata <= {armed, 17'h0, 6'(bidx), 8'(ptr)};
            `PWS_ADDR_COUNT:   reg_rdata <= samples;
            default:           reg_rdata <= 32'h00000000;
         endcase
      end else begin
         reg_rdata <= 32'h00000000;
      end
   end
endmodule
`default_nettype wire

// [test/pws_source_asserts.sv]
// Purpose: port checks of the waveform source
// Assumes: one clock, async active-high reset
// Notes:   sees top ports only, mode is not known here
`timescale 1ns/1ps
`default_nettype none
module pws_source_asserts #(
   parameter int SITES = 4,
   parameter int PINS  = 32
) (
   // clock, reset, register port
   input  wire logic                  core_clk,
   input  wire logic                  reset,
   input  wire logic [7:0]            reg_addr,
   input  wire logic                  reg_rd,
   input  wire logic [31:0]           reg_rdata,
   // vectors and pins
   input  wire pws_pkg::pws_vec_t     vec,
   input  wire logic [SITES*PINS-1:0] drive_from_src,
   input  wire logic [SITES*PINS-1:0] pin_data,
   input  wire logic [SITES*PINS-1:0] pin_drive
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);
   logic src;  // sourcing vector taken
   logic go;   // stream-begin vector taken
   assign src = vec.valid && vec.op == pws_pkg::PWS_OP_SOURCE;
   assign go  = vec.valid && vec.op == pws_pkg::PWS_OP_START;
   // begin, then counters read at once
   sequence s_start_peek;
      go ##1 (reg_rd && !vec.valid && reg_addr inside {8'h05, 8'h06});
   endsequence
   AST_DRV_CAUSE: assert property (|pin_drive |-> $past(src))
      else $error("pin driven without a sourcing vector");
   AST_DRV_MASK: assert property ((pin_drive & ~$past(drive_from_src)) == '0)
      else $error("pin driven outside the drive mask");
   AST_IDLE_VEC: assert property (!vec.valid |=> pin_drive == '0)
      else $error("pin driven after an idle cycle");
   AST_START_QUIET: assert property (go |=> pin_drive == '0)
      else $error("pin driven after stream begin");
   AST_DATA_HOLD: assert property (pin_drive == '0 && $past(!src) |-> $stable(pin_data))
      else $error("pin data moved without sourcing");
   AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == '0)
      else $error("read data outside its cycle");
   AST_UNMAPPED: assert property (reg_rd && reg_addr > 8'h06 |=> reg_rdata == '0)
      else $error("unmapped read not zero");
   AST_START_CLEAR: assert property (s_start_peek |=> reg_rdata[30:0] == '0)
      else $error("pointer or count not cleared by begin");
endmodule
`default_nettype wire

// [test/pws_pin_model.sv]
// Purpose: tested-device pins as the source sees them
// Assumes: one level per site and pin
// Notes:   no pull resistor, a released pin flips each cycle
`timescale 1ns/1ps
`default_nettype none
module pws_pin_model #(
   parameter int N = 128
) (
   // clock and source outputs
   input  wire logic         core_clk,
   input  wire logic [N-1:0] pin_data,
   input  wire logic [N-1:0] pin_drive,
   // level on each pin
   output logic      [N-1:0] level
);
   logic [N-1:0] last;  // previous level
   // flipping stale data so it never passes for a driven value
   assign level = (pin_data & pin_drive) | (~last & ~pin_drive);
   always_ff @(posedge core_clk) last <= level;
endmodule
`default_nettype wire

// [test/tb_top.sv]
// Purpose: random and corner stimulus for the waveform source
// Assumes: two sites of 32 pins
// Notes:   expectations come from bench functions
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam int S = 2;
   localparam int P = 32;
   localparam int N = S * P;
   logic              core_clk, reset, reg_wr, reg_rd;
   logic [7:0]        reg_addr;
   logic [31:0]       reg_wdata, reg_rdata, rv;
   pws_pkg::pws_vec_t vec;
   logic [N-1:0]      dfs, pin_data, pin_drive, level;
   logic [31:0]       mem [S][4];  // sample columns per site
   int                error_cnt, tests_run;
   int                cyc = 0;
   pws_source #(.SITES(S), .PINS(P), .DEPTH(256), .AW(8)) u_dut (.core_clk(core_clk),
      .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .vec(vec), .drive_from_src(dfs),
      .pin_data(pin_data), .pin_drive(pin_drive));
   pws_pin_model #(.N(N)) u_pins (.core_clk(core_clk), .pin_data(pin_data),
      .pin_drive(pin_drive), .level(level));
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   // hang guard, far above the run length
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt = error_cnt + 1;
         end_of_test();
      end
   end
   task automatic cmp(input logic [N-1:0] got, input logic [N-1:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge core_clk);
      reg_wr    <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge core_clk);
      reg_rd   <= 1'b0;
      #1 rv = reg_rdata;
   endtask
   // one vector, outputs sampled after the answer edge
   task automatic step(input pws_pkg::pws_op_t op, input logic [N-1:0] d);
      @(posedge core_clk);
      vec <= '{1'b1, op};
      dfs <= d;
      @(posedge core_clk);
      vec <= '0;
      #1;
   endtask
   function automatic logic [N-1:0] exp_pins(input logic par, lsb, ps, input int w, sm, b, pm);
      logic [N-1:0] r;
      logic [31:0]  x;
      r = '0;
      for (int s = 0; s < S; s++) begin
         x = mem[ps ? s : 0][sm];
         for (int p = 0; p < P; p++) r[s*P+p] = x[31-p];
         if (!par) r[s*P+pm] = x[lsb ? b : w-1-b];
      end
      return r;
   endfunction
   task automatic end_of_test();
      if (error_cnt == 0 && tests_run > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   initial begin
      logic [N-1:0] d;
      logic [2:0]   m;
      int           w, pm;
      error_cnt = 0;
      tests_run = 0;
      reset = 1'b1;
      {reg_wr, reg_rd, reg_addr, reg_wdata, dfs} = '0;
      vec = '0;
      rv = $urandom(73);
      repeat (20) @(posedge core_clk);
      reset <= 1'b0;
      rd(8'h01);
      cmp(rv, 32'h20);
      rd(8'h07);
      cmp(rv, 0);
      // each site gets its own column of four samples, site index above the 8-bit sample index
      for (int s = 0; s < S; s++) begin
         wr(8'h03, 32'(s) << 8);
         for (int i = 0; i < 4; i++) begin
            mem[s][i] = $urandom;
            wr(8'h04, mem[s][i]);
         end
      end
      // every mode: parallel, lsb first, per site
      for (int k = 0; k < 8; k++) begin
         m  = 3'(k);
         w  = (k == 0) ? 1 : (k == 2) ? 32 : 1 + $urandom % 32;
         pm = $urandom % 32;
         wr(8'h00, {29'h0, m[2], m[1], m[0]});
         wr(8'h01, w);
         wr(8'h02, pm);
         d = m[0] ? '1 : '0;
         for (int s = 0; s < S; s++) d[s*P+pm] = 1'b1;
         step(pws_pkg::PWS_OP_START, '0);
         for (int sm = 0; sm < 2; sm++) begin
            for (int b = 0; b < (m[0] ? 1 : w); b++) begin
               step(pws_pkg::PWS_OP_SOURCE, d);
               cmp(pin_drive, d);
               cmp(level & d, exp_pins(m[0], m[1], m[2], w, sm, b, pm) & d);
            end
         end
         rd(8'h06);
         cmp(rv, 2);
      end
      @(posedge core_clk);
      vec <= '{1'b1, pws_pkg::PWS_OP_START};
      @(posedge core_clk);
      vec      <= '0;
      reg_addr <= 8'h06;
      reg_rd   <= 1'b1;
      @(posedge core_clk);
      reg_rd   <= 1'b0;
      #1 cmp(reg_rdata, 0);
      end_of_test();
   end
endmodule
bind pws_source pws_source_asserts #(.SITES(SITES), .PINS(PINS)) u_chk (.core_clk(core_clk),
   .reset(reset), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .vec(vec),
   .drive_from_src(drive_from_src), .pin_data(pin_data), .pin_drive(pin_drive));
`default_nettype wire
